// ---- hw/spi_eeprom_command_status.sv ----
`timescale 1ns/10ps
module spi_eeprom_command_status
  import spi_eeprom_pkg::*;
#(
  parameter int PROG_CYC = PROG_CYCLES,   // standard cycle length in clocks
  parameter int FAST_CYC = FAST_CYCLES    // fast cycle length in clocks
)(
  input  wire logic clk_sys_in,           // 20 MHz system clock
  input  wire logic resetn_in,            // async reset, active low
  input  wire logic cs_n_in,              // chip select pin
  input  wire logic sck_in,               // serial clock pin
  input  wire logic si_in,                // serial data in pin
  input  wire logic hold_n_in,            // pause pin
  input  wire logic write_protect_n_in,   // write protect pin
  output logic      so_out,               // serial data out
  output logic      so_oe_n_out,          // low while driving so_out
  output logic      busy_out              // programming cycle running
);
  //----------------------------------------------------------------------------
  // parameter check
  //----------------------------------------------------------------------------
  // the page commit walks one byte per clock, so a cycle must outlast it
  if (PROG_CYC <= PAGE_BYTES || FAST_CYC <= PAGE_BYTES ||
      PROG_CYC >= 2**TIMER_W || FAST_CYC >= 2**TIMER_W)
  begin : g_bad_cycles
    $error("program cycle counts out of range");
  end

  //----------------------------------------------------------------------------
  // input synchronisers
  //----------------------------------------------------------------------------
  pins_t pins_raw;                        // packed view of the pins
  pins_t sync1_ff;                        // first stage, read by stage two only
  pins_t sync2_ff;                        // stable copy
  pins_t prev_ff;                         // stable copy one clock older
  assign pins_raw = '{cs_n: cs_n_in, sck: sck_in, si: si_in,
                      hold_n: hold_n_in, wp_n: write_protect_n_in};

  // two flops per pin, then one more for edge detection
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      // idle pin levels, so no false clock or pause edge follows reset
      sync1_ff <= 5'h13;
      sync2_ff <= 5'h13;
      prev_ff  <= 5'h13;
    end
    else
    begin
      sync1_ff <= pins_raw;
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
    end
  end

  //----------------------------------------------------------------------------
  // edge events
  //----------------------------------------------------------------------------
  logic active;                           // selected and not paused
  logic sck_rise;                         // serial clock rising edge
  logic sck_fall;                         // serial clock falling edge
  logic cs_rise;                          // session end
  assign active   = !sync2_ff.cs_n && sync2_ff.hold_n;
  assign sck_rise = active && sync2_ff.sck && !prev_ff.sck;
  assign sck_fall = active && !sync2_ff.sck && prev_ff.sck;
  assign cs_rise  = sync2_ff.cs_n && !prev_ff.cs_n;

  //----------------------------------------------------------------------------
  // storage
  //----------------------------------------------------------------------------
  logic [7:0] mem_arr [2**ARRAY_ADDR_W];  // main array
  logic [7:0] idpg_arr [PAGE_BYTES];      // identification page
  logic [7:0] pbuf_arr [PAGE_BYTES];      // page load buffer

  //----------------------------------------------------------------------------
  // session state
  //----------------------------------------------------------------------------
  state_t                  st_ff, nxt_st;
  logic [2:0]              bit_ff, nxt_bit;          // bit within byte
  logic [7:0]              sh_ff, nxt_sh;            // input shifter
  logic [7:0]              out_ff, nxt_out;          // output shifter
  logic [23:0]             addr_ff, nxt_addr;        // address pointer
  logic [1:0]              abyte_ff, nxt_abyte;      // address bytes taken
  logic                    isrd_ff, nxt_isrd;        // address phase is a read
  logic                    wseen_ff, nxt_wseen;      // data byte loaded
  logic                    wen_ff, nxt_wen;          // enable pending
  logic                    wdis_ff, nxt_wdis;        // disable pending
  logic                    spend_ff, nxt_spend;      // status write pending
  logic [7:0]              sbyte_ff, nxt_sbyte;      // status byte received
  logic                    rdid_ff, nxt_rdid;        // id page was read
  logic                    wrid_ff, nxt_wrid;        // cycle targets id page
  logic [PAGE_BYTES-1:0]   mask_ff, nxt_mask;        // loaded buffer bytes
  logic [ARRAY_ADDR_W-1:8] page_ff, nxt_page;        // page being written
  status_t                 stat_ff, nxt_stat;        // status byte
  logic [TIMER_W-1:0]      tmr_ff, nxt_tmr;          // cycle timer
  logic [8:0]              cidx_ff, nxt_cidx;        // commit index
  logic                    so_ff, nxt_so;
  logic                    oe_n_ff, nxt_oe_n;

  logic [7:0]              byte_in;                  // byte completing now
  logic                    byte_done;
  logic [23:0]             rd_addr;                  // address to fetch
  logic [7:0]              rd_byte;                  // fetched byte
  logic [1:0]              lock;                     // lock pair
  logic                    region_hit;               // page inside lock range
  logic                    wr_ok;                    // write may start
  logic                    guard;                    // pin protection active
  logic [7:0]              opc;                      // decoded opcode

  // msb first: new bit enters at the bottom
  // msb first shift
  assign byte_in   = {sh_ff[6:0], sync2_ff.si};
  assign byte_done = sck_rise && (bit_ff == 3'h7);
  assign opc       = byte_in;
  assign lock      = {stat_ff.region_lock_hi, stat_ff.region_lock_lo};
  assign rd_addr   = (st_ff == ST_ADDR) ? {addr_ff[15:0], byte_in} : addr_ff + 24'h00_0001;
  assign rd_byte   = stat_ff.id_page_select ? idpg_arr[rd_addr[7:0]]
                                            : mem_arr[rd_addr[ARRAY_ADDR_W-1:0]];
  always_comb
  begin
    case (lock)
      LOCK_QUARTER: region_hit = (page_ff[17:16] == 2'h3);
      LOCK_HALF:    region_hit = page_ff[17];
      LOCK_ALL:     region_hit = 1'b1;
      default:      region_hit = 1'b0;
    endcase
  end
  assign guard = stat_ff.pin_guard_enable && !sync2_ff.wp_n;
  // locked regions refused; id page follows lock-all and its own lock
  assign wr_ok = wseen_ff && stat_ff.write_latch_flag &&
                 (wrid_ff ? (lock != LOCK_ALL && !stat_ff.id_page_lock) : !region_hit);

  // next-state logic for the whole session and status byte
  always_comb
  begin
    nxt_st = st_ff;   nxt_bit = bit_ff;   nxt_sh = sh_ff;   nxt_out = out_ff;
    nxt_addr = addr_ff;   nxt_abyte = abyte_ff;   nxt_isrd = isrd_ff;
    nxt_wseen = wseen_ff; nxt_wen = wen_ff;  nxt_wdis = wdis_ff;
    nxt_spend = spend_ff; nxt_sbyte = sbyte_ff; nxt_rdid = rdid_ff;
    nxt_wrid = wrid_ff;  nxt_mask = mask_ff; nxt_page = page_ff;
    nxt_stat = stat_ff;  nxt_tmr = tmr_ff;  nxt_cidx = cidx_ff;
    nxt_so = so_ff;
    // commit walk and cycle timer
    if (cidx_ff != COMMIT_DONE)
      nxt_cidx = cidx_ff + 9'h001;
    if (stat_ff.busy_flag)
    begin
      nxt_tmr = tmr_ff - 24'h00_0001;
      if (tmr_ff == 24'h00_0001)
      begin
        nxt_stat.busy_flag = 1'b0;
        nxt_stat.write_latch_flag = 1'b0;
        if (wrid_ff)
          nxt_stat.id_page_select = 1'b0;
        nxt_wrid = 1'b0;
      end
    end
    if (sync2_ff.cs_n)
    begin
      nxt_st = ST_CMD;
      nxt_bit = 3'h0;
      nxt_so = 1'b0;
    end
    if (cs_rise)
    begin
      if (wen_ff)
        nxt_stat.write_latch_flag = 1'b1;
      if (wdis_ff)
        nxt_stat.write_latch_flag = 1'b0;
      // read of id page clears select
      if (rdid_ff)
        nxt_stat.id_page_select = 1'b0;
      if (wr_ok)
      begin
        nxt_stat.busy_flag = 1'b1;
        nxt_tmr = stat_ff.fast_program_sel ? TIMER_W'(FAST_CYC) : TIMER_W'(PROG_CYC);
        nxt_cidx = 9'h000;
      end
      else
        nxt_wrid = 1'b0;
      if (spend_ff && !guard)
      begin
        // lock pair and other writable bits
        nxt_stat.pin_guard_enable = sbyte_ff[7];
        nxt_stat.fast_program_sel = sbyte_ff[5];
        nxt_stat.region_lock_hi   = sbyte_ff[3];
        nxt_stat.region_lock_lo   = sbyte_ff[2];
        if (!(sbyte_ff[6] && sbyte_ff[4]))
        begin
          nxt_stat.id_page_select = sbyte_ff[6];
          nxt_stat.id_page_lock   = stat_ff.id_page_lock | sbyte_ff[4];
        end
        nxt_stat.busy_flag = 1'b1;
        nxt_tmr = stat_ff.fast_program_sel ? TIMER_W'(FAST_CYC) : TIMER_W'(PROG_CYC);
      end
      nxt_wen = 1'b0;  nxt_wdis = 1'b0;  nxt_spend = 1'b0;
      nxt_wseen = 1'b0; nxt_rdid = 1'b0;
    end
    if (sck_fall && (st_ff == ST_RDATA || st_ff == ST_SREAD))
    begin
      nxt_so  = out_ff[7];
      nxt_out = {out_ff[6:0], 1'b0};
    end
    if (sck_rise)
    begin
      nxt_sh  = byte_in;
      nxt_bit = bit_ff + 3'h1;
    end
    if (byte_done)
    begin
      case (st_ff)
        ST_CMD:
        begin
          nxt_st = ST_IGNORE;
          if (!stat_ff.busy_flag || opc == OPC_STAT_READ)
          begin
            case (opc)
              OPC_WR_ENABLE:  nxt_wen = 1'b1;
              OPC_WR_DISABLE: nxt_wdis = 1'b1;
              OPC_STAT_READ:
              begin
                nxt_st = ST_SREAD;
                nxt_out = nxt_stat;
              end
              OPC_STAT_WRITE:
                if (stat_ff.write_latch_flag)
                  nxt_st = ST_SWRITE;
              OPC_MEM_READ:
              begin
                nxt_st = ST_ADDR;
                nxt_isrd = 1'b1;
                nxt_abyte = 2'h0;
              end
              OPC_MEM_WRITE:
                if (stat_ff.write_latch_flag)
                begin
                  nxt_st = ST_ADDR;
                  nxt_isrd = 1'b0;
                  nxt_abyte = 2'h0;
                  nxt_mask = '0;
                  nxt_wrid = stat_ff.id_page_select;
                end
              default: nxt_st = ST_IGNORE;
            endcase
          end
        end
        ST_ADDR:
        begin
          nxt_addr = {addr_ff[15:0], byte_in};
          nxt_abyte = abyte_ff + 2'h1;
          if (abyte_ff == 2'h2)
          begin
            nxt_page = nxt_addr[ARRAY_ADDR_W-1:8];
            nxt_st = isrd_ff ? ST_RDATA : ST_WDATA;
            nxt_rdid = isrd_ff && stat_ff.id_page_select;
            nxt_out = rd_byte;
          end
        end
        ST_RDATA:
        begin
          // sequential read, wraps at the top
          nxt_addr = rd_addr;
          nxt_out = rd_byte;
        end
        ST_WDATA:
        begin
          // page load rolls over inside the page
          nxt_mask[addr_ff[7:0]] = 1'b1;
          nxt_addr[7:0] = addr_ff[7:0] + 8'h01;
          nxt_wseen = 1'b1;
        end
        ST_SREAD: nxt_out = stat_ff;     // live busy bit
        ST_SWRITE:
        begin
          nxt_sbyte = byte_in;
          nxt_spend = 1'b1;
        end
        default: nxt_st = ST_IGNORE;
      endcase
    end
    // output off unless selected, unpaused and sending
    nxt_oe_n = !(active && (nxt_st == ST_RDATA || nxt_st == ST_SREAD));
  end

  // register the session and status state
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      st_ff <= ST_CMD;   bit_ff <= 3'h0;   sh_ff <= 8'h00;   out_ff <= 8'h00;
      addr_ff <= 24'h00_0000; abyte_ff <= 2'h0; isrd_ff <= 1'b0;
      wseen_ff <= 1'b0;  wen_ff <= 1'b0;   wdis_ff <= 1'b0;  spend_ff <= 1'b0;
      sbyte_ff <= 8'h00; rdid_ff <= 1'b0;  wrid_ff <= 1'b0;  mask_ff <= '0;
      page_ff <= '0;     stat_ff <= STATUS_RESET;  tmr_ff <= '0;
      cidx_ff <= COMMIT_DONE;  so_ff <= 1'b0;  oe_n_ff <= 1'b1;
    end
    else
    begin
      st_ff <= nxt_st;   bit_ff <= nxt_bit; sh_ff <= nxt_sh;  out_ff <= nxt_out;
      addr_ff <= nxt_addr; abyte_ff <= nxt_abyte; isrd_ff <= nxt_isrd;
      wseen_ff <= nxt_wseen; wen_ff <= nxt_wen; wdis_ff <= nxt_wdis;
      spend_ff <= nxt_spend; sbyte_ff <= nxt_sbyte; rdid_ff <= nxt_rdid;
      wrid_ff <= nxt_wrid; mask_ff <= nxt_mask;  page_ff <= nxt_page;
      stat_ff <= nxt_stat; tmr_ff <= nxt_tmr;   cidx_ff <= nxt_cidx;
      so_ff <= nxt_so;   oe_n_ff <= nxt_oe_n;
    end
  end

  // memory writes: buffer loads on byte, array commits one byte per clock
  always_ff @(posedge clk_sys_in)
  begin
    if (byte_done && st_ff == ST_WDATA)
      pbuf_arr[addr_ff[7:0]] <= byte_in;
    if (cidx_ff != COMMIT_DONE && mask_ff[cidx_ff[7:0]])
    begin
      if (wrid_ff)
        idpg_arr[cidx_ff[7:0]] <= pbuf_arr[cidx_ff[7:0]];
      else
        mem_arr[{page_ff, cidx_ff[7:0]}] <= pbuf_arr[cidx_ff[7:0]];
    end
  end

  assign so_out      = so_ff;
  assign so_oe_n_out = oe_n_ff;
  assign busy_out    = stat_ff.busy_flag;

  //----------------------------------------------------------------------------
  // checks
  //----------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);

  a_oe_when_deselected: assert property (sync2_ff.cs_n |=> so_oe_n_out)
    else $error("output driven while deselected");
  a_so_moves_on_fall: assert property ($changed(so_out) && !$past(sync2_ff.cs_n)
    |-> $past(sck_fall))
    else $error("serial output changed off a falling edge");
  a_bad_opcode_ignored: assert property (byte_done && st_ff == ST_CMD && opc[7:3] != 5'h00
    |=> st_ff == ST_IGNORE)
    else $error("unknown opcode not ignored");
  a_busy_blocks_cmds: assert property (byte_done && st_ff == ST_CMD && busy_out &&
    opc != OPC_STAT_READ |=> st_ff == ST_IGNORE && !wen_ff)
    else $error("command taken while busy");
  a_latch_set_enable: assert property (cs_rise && wen_ff |=> stat_ff.write_latch_flag)
    else $error("enable did not set latch");
  a_cycle_clears_latch: assert property ($fell(busy_out) |-> !stat_ff.write_latch_flag)
    else $error("latch survived program cycle");
  a_cycle_min_len: assert property ($rose(busy_out) |-> busy_out [*8])
    else $error("program cycle too short");
  a_both_ids_kept: assert property (cs_rise && spend_ff && sbyte_ff[6] && sbyte_ff[4] &&
    !rdid_ff |=> $stable(stat_ff.id_page_select) && $stable(stat_ff.id_page_lock))
    else $error("select and lock changed together");
  a_guard_blocks_stat: assert property (cs_rise && spend_ff && guard
    |=> $stable(lock) && !$rose(busy_out))
    else $error("guarded status write applied");
  a_id_lock_sticky: assert property (stat_ff.id_page_lock |=> stat_ff.id_page_lock)
    else $error("id page lock cleared");
  a_id_read_clears: assert property (cs_rise && rdid_ff |=> !stat_ff.id_page_select)
    else $error("id select kept after read");

  c_status_read: cover property (byte_done && st_ff == ST_CMD && opc == OPC_STAT_READ);
  c_mem_write_cycle: cover property (cs_rise && wr_ok);
  c_status_write: cover property (cs_rise && spend_ff && !guard);
  c_mem_read: cover property (st_ff == ST_RDATA && byte_done);
endmodule : spi_eeprom_command_status

// ---- inc/spi_eeprom_pkg.sv ----
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package spi_eeprom_pkg;
  // timing figures and derived cycle counts
  localparam int CLK_PERIOD_NS  = 50;
  localparam int PROG_TIME_MS   = 6;                 // standard program cycle
  localparam int FAST_TIME_MS   = 3;                 // fast program cycle
  localparam int PROG_CYCLES    = PROG_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int FAST_CYCLES    = FAST_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int POWERUP_US     = 100;               // host side wait only
  // geometry
  localparam int ARRAY_ADDR_W   = 18;                // significant array bits
  localparam int PAGE_BYTES     = 256;
  localparam int TIMER_W        = 24;
  // opcodes
  localparam logic [7:0] OPC_WR_ENABLE  = 8'h06;
  localparam logic [7:0] OPC_WR_DISABLE = 8'h04;
  localparam logic [7:0] OPC_STAT_READ  = 8'h05;
  localparam logic [7:0] OPC_STAT_WRITE = 8'h01;
  localparam logic [7:0] OPC_MEM_READ   = 8'h03;
  localparam logic [7:0] OPC_MEM_WRITE  = 8'h02;
  // lock pair encodings
  localparam logic [1:0] LOCK_NONE    = 2'h0;
  localparam logic [1:0] LOCK_QUARTER = 2'h1;
  localparam logic [1:0] LOCK_HALF    = 2'h2;
  localparam logic [1:0] LOCK_ALL     = 2'h3;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [8:0] COMMIT_DONE  = 9'h100;      // page commit finished

  // status byte, bit 7 first
  typedef struct packed {
    logic pin_guard_enable;
    logic id_page_select;
    logic fast_program_sel;
    logic id_page_lock;
    logic region_lock_hi;
    logic region_lock_lo;
    logic write_latch_flag;
    logic busy_flag;
  } status_t;

  // serial pins as seen after synchronising
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic hold_n;
    logic wp_n;
  } pins_t;

  // session states
  typedef enum logic [2:0] {
    ST_CMD    = 3'b000,
    ST_ADDR   = 3'b001,
    ST_RDATA  = 3'b010,
    ST_WDATA  = 3'b011,
    ST_SREAD  = 3'b100,
    ST_SWRITE = 3'b101,
    ST_IGNORE = 3'b110
  } state_t;
endpackage : spi_eeprom_pkg

// ---- tb/spi_eeprom_command_status_tb.sv ----
`timescale 1ns/10ps
module spi_eeprom_command_status_tb
  import spi_eeprom_pkg::*;
;
  localparam int PC = 400;  // shortened standard cycle
  localparam int FC = 300;  // shortened fast cycle
  logic       clk_sys_in = 1'b0;
  logic       resetn_in  = 1'b0;
  logic       wp_n       = 1'b1;
  logic       cs_n, sck, si, hold_n, so, oe_n, busy, rx_v;
  logic [7:0] rx_b, op, d1, d2;
  logic [7:0] exp_q[$];     // expected read bytes, oldest first
  int         error_cnt = 0;
  int         n_tests   = 0;
  int         busy_cnt  = 0;
  int         cyc       = 0;

  always #25 clk_sys_in = ~clk_sys_in;

  spi_eeprom_command_status #(.PROG_CYC(PC), .FAST_CYC(FC)) spi_eeprom_command_status_i (
    .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .cs_n_in(cs_n), .sck_in(sck),
    .si_in(si), .hold_n_in(hold_n), .write_protect_n_in(wp_n), .so_out(so),
    .so_oe_n_out(oe_n), .busy_out(busy));

  spi_host_model spi_host_model_i (
    .clk_in(clk_sys_in), .so_in(oe_n ? ~so : so), .cs_n_out(cs_n), .sck_out(sck), .si_out(si),
    .hold_n_out(hold_n), .rx_byte_out(rx_b), .rx_valid_out(rx_v));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up

  task automatic cmd(input logic [7:0] c);
    spi_host_model_i.frame('{c}, 0, 1'b0);
  endtask : cmd

  task automatic rd_st(input logic [7:0] e);
    exp_q.push_back(e);
    spi_host_model_i.frame('{OPC_STAT_READ}, 1, 1'b0);
    check(oe_n, 1'b1);
  endtask : rd_st

  task automatic rd_mem(input logic [23:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    spi_host_model_i.frame('{OPC_MEM_READ, a[23:16], a[15:8], a[7:0]}, 1, 1'b1);
  endtask : rd_mem

  // session that may start a cycle; e<0 means any nonzero length
  task automatic prog(input logic [7:0] tx[$], input int e, input bit peek);
    busy_cnt = 0;
    spi_host_model_i.frame(tx, 0, 1'b0);
    if (peek)
    begin
      cmd(OPC_WR_DISABLE);
      rd_st(8'h03);
    end
    for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(negedge clk_sys_in);
    if (e < 0) check(busy_cnt != 0, 1'b1); else check(busy_cnt, e);
    $display("session done, busy %0d", busy_cnt);
  endtask : prog

  // result watcher and cycle ceiling
  always @(posedge clk_sys_in)
    if (rx_v === 1'b1) check(rx_b, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);

  always @(negedge clk_sys_in)
  begin
    cyc++;
    if (busy === 1'b1) busy_cnt++;
    if (cyc == 40000)
    begin
      error_cnt++;
      wrap_up();
    end
  end

  initial
  begin
    op = 8'($urandom(32'h0000_0323));
    d1 = 8'($urandom);
    d2 = 8'($urandom);
    repeat (12) @(negedge clk_sys_in);
    resetn_in = 1'b1;
    repeat (POWERUP_US * 1000 / CLK_PERIOD_NS) @(negedge clk_sys_in);
    rd_st(8'h00);
    cmd(OPC_WR_ENABLE);
    rd_st(8'h02);
    repeat (3) cmd(op ^ 8'($urandom) | 8'h10);
    rd_st(8'h02);
    cmd(OPC_WR_DISABLE);
    rd_st(8'h00);
    cmd(OPC_WR_ENABLE);
    prog('{OPC_MEM_WRITE, 8'hFC, 8'h01, 8'h23, d1, d2}, PC, 1);
    rd_st(8'h00);
    prog('{OPC_MEM_WRITE, 8'h00, 8'h01, 8'h23, ~d1}, 0, 0);
    rd_mem(24'h00_0123, d1);
    rd_mem(24'hC0_0124, d2);
    cmd(OPC_WR_ENABLE);
    prog('{OPC_STAT_WRITE, 8'h04}, PC, 0);
    rd_st(8'h04);
    cmd(OPC_WR_ENABLE);
    prog('{OPC_MEM_WRITE, 8'h03, 8'h00, 8'h00, d2}, 0, 0);
    cmd(OPC_WR_ENABLE);
    prog('{OPC_MEM_WRITE, 8'h02, 8'hFF, 8'hFF, d2}, PC, 0);
    cmd(OPC_WR_ENABLE);
    prog('{OPC_STAT_WRITE, 8'hA0}, -1, 0);
    cmd(OPC_WR_ENABLE);
    prog('{OPC_MEM_WRITE, 8'h03, 8'h00, 8'h00, d1}, FC, 0);
    wp_n = 1'b0;
    cmd(OPC_WR_ENABLE);
    prog('{OPC_STAT_WRITE, 8'h00}, 0, 0);
    cmd(OPC_WR_DISABLE);
    rd_st(8'hA0);
    wp_n = 1'b1;
    cmd(OPC_WR_ENABLE);
    prog('{OPC_STAT_WRITE, 8'h50}, -1, 0);
    rd_st(8'h00);
    cmd(OPC_WR_ENABLE);
    prog('{OPC_STAT_WRITE, 8'h40}, -1, 0);
    cmd(OPC_WR_ENABLE);
    prog('{OPC_MEM_WRITE, 8'h00, 8'h00, 8'h05, d2}, PC, 0);
    rd_st(8'h00);
    // lock the id page, then select it again and try to overwrite it
    cmd(OPC_WR_ENABLE);
    prog('{OPC_STAT_WRITE, 8'h10}, -1, 0);
    cmd(OPC_WR_ENABLE);
    prog('{OPC_STAT_WRITE, 8'h40}, -1, 0);
    rd_st(8'h50);
    cmd(OPC_WR_ENABLE);
    prog('{OPC_MEM_WRITE, 8'h00, 8'h00, 8'h05, ~d2}, 0, 0);
    rd_mem(24'hFF_FF05, d2);
    rd_st(8'h12);
    $display("all scenarios run");
    wrap_up();
  end
endmodule : spi_eeprom_command_status_tb

// ---- tb/spi_host_model.sv ----
`timescale 1ns/10ps
module spi_host_model (
  input  wire logic       clk_in,       // bench clock, drives on falling edge
  input  wire logic       so_in,        // device serial output
  output logic            cs_n_out,     // chip select, active low
  output logic            sck_out,      // serial clock, idles low
  output logic            si_out,       // serial data to device
  output logic            hold_n_out,   // pause line, active low
  output logic [7:0]      rx_byte_out,  // byte just shifted in
  output logic            rx_valid_out  // one clock per received byte
);
  initial
  begin
    cs_n_out     = 1'b1;
    sck_out      = 1'b0;
    si_out       = 1'b0;
    hold_n_out   = 1'b1;
    rx_byte_out  = 8'h00;
    rx_valid_out = 1'b0;
  end

  // one bit; sampled late in the high phase since the device output lags by sync stages
  // mode 0 edges
  task automatic bit_io(input logic b, output logic r);
    si_out = b;
    repeat (4) @(negedge clk_in);
    sck_out = 1'b1;
    repeat (4) @(negedge clk_in);
    r       = so_in;
    sck_out = 1'b0;
  endtask : bit_io

  // one session: send bytes, optional pause, clock in nrx bytes
  task automatic frame(input logic [7:0] tx[$], input int nrx, input bit pause);
    logic [7:0] sh;
    cs_n_out = 1'b0;
    repeat (4) @(negedge clk_in);
    foreach (tx[i]) for (int k = 7; k >= 0; k--) bit_io(tx[i][k], sh[0]);
    if (pause)
    begin
      // let the last clock fall reach the device before pausing it
      repeat (4) @(negedge clk_in);
      hold_n_out = 1'b0;
      repeat (6) @(negedge clk_in);
      hold_n_out = 1'b1;
    end
    for (int n = 0; n < nrx; n++)
    begin
      for (int k = 7; k >= 0; k--) bit_io(1'b0, sh[k]);
      rx_byte_out  = sh;
      rx_valid_out = 1'b1;
      @(negedge clk_in);
      rx_valid_out = 1'b0;
    end
    repeat (4) @(negedge clk_in);
    // close session; released data line flips so no stale value lingers
    cs_n_out = 1'b1;
    si_out   = ~si_out;
    repeat (8) @(negedge clk_in);
  endtask : frame
endmodule : spi_host_model
